// File: rtl/hash_link_consts.svh
// Constants shared by both ends of the hashing chip serial control link.
`ifndef HASH_LINK_CONSTS_SVH
`define HASH_LINK_CONSTS_SVH

// ==========================================================================
// Command codes, one bit per command, and the largest length byte.
`define CMD_TASK_WRITE 8'h01
`define CMD_FORCE_SW 8'h02
`define CMD_READ_SOL 8'h04
`define CMD_SET_CLOCK 8'h08
`define CMD_SET_MASK 8'h20
`define CMD_MAX_LEN 8'h4f
`define CMD_BIT_TASK 0
`define CMD_BIT_FORCE 1
`define CMD_BIT_READ 2
`define CMD_BIT_CLOCK 3
`define CMD_BIT_MASK 5

// ==========================================================================
// Job image and solution ring geometry.
`define JOB_BYTES 8'd80
`define JOB_MASK_WORD 5'd19
`define RING_LAST 4'd11
`define OUT_STATUS_IDX 7'd0
`define OUT_CSUM_IDX 7'd1
`define OUT_SOL_FIRST 7'd2
`define OUT_SOL_LAST 7'd49
`define OUT_SCSUM_IDX 7'd50
`define RESET_PULSES 3'd4

// ==========================================================================
// Encodings and fields.
`define SOL_XOR 32'h0aaaaaaa
`define MASK_XOR 16'haaaa
`define MARK_BODY 28'hffffffc
`define CLK_FLAG_HI 19
`define CLK_FLAG_LO 12
`define CLK_CODE_HI 18:13
`define CLK_CODE_LO 11:6
`define MASK_COUNT 19:16

// ==========================================================================
// Host register map (byte addresses) and link timing.
`define HREG_CTRL 10'h000
`define HREG_RX_BASE 10'h100
`define HREG_TX_BASE 10'h200
`define HCTRL_GO 16
`define HCTRL_BUSY 31
`define SYS_CLK_NS 40
`define SCK_HALF_NS 320
`define SCK_HALF_CYC ((`SCK_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

// File: rtl/hash_link_pkg.sv
// Types shared by both ends of the hashing chip serial control link.
package hash_link_pkg;

	// ==========================================================================
	// Device command engine states.
	typedef enum logic [2:0] {S_IDLE, S_CMD, S_LEN, S_DATA, S_EXEC, S_OUT} dev_state_t;

	// ==========================================================================
	// Controller sequencer states.
	typedef enum logic [2:0] {H_IDLE, H_RST, H_TX, H_RX, H_END} host_state_t;

endpackage

// File: rtl/hash_link_if.sv
// Two-wire serial link joining the controller and the hashing chip.
interface hash_link_if;

	// ==========================================================================
	// Serial clock, made by the controller.
	logic sck;
	// Controller side of the shared data line.
	logic host_do;
	logic host_oe;
	// Device side of the shared data line.
	logic dev_do;
	logic dev_oe;
	// Resolved line level; an idle line is pulled high.
	logic sd;

	// The device wins if both drive, which only a protocol fault can cause.
	assign sd = dev_oe ? dev_do : (host_oe ? host_do : 1'b1);

	modport device (input sck, input sd, output dev_do, output dev_oe);
	modport host (output sck, input sd, output host_do, output host_oe);

endinterface

// File: rtl/sync2.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
module sync2 #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// ==========================================================================
	// First stage is read only by the second stage.
	logic [W-1:0] meta_r;

	// Both stages freeze with the clock enable.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule

// File: rtl/hash_dev.sv
// Hashing chip end of the serial control link: command decode and execution.
module hash_dev
	import hash_link_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	hash_link_if.device lnk,
	input wire logic task_done,
	input wire logic sol_valid,
	input wire logic [31:0] sol_value,
	input wire logic [3:0] progress_nib,
	input wire logic [4:0] job_rd_idx,
	output logic [31:0] job_rd_data,
	output logic active_buf,
	output logic [31:0] clk_ctrl,
	output logic clk_load,
	output logic [31:0] fix_bits_mask,
	output logic [15:0] fix_value
);
`include "hash_link_consts.svh"

	// ==========================================================================
	// Pin synchronisation and edge detection.
	logic [1:0] sync_q; // Synchronised {sck, sd}.
	logic sck_p_r; // Previous synchronised clock.
	logic sd_p_r; // Previous synchronised data.
	logic [2:0] pulse_r; // Data pulses seen while the clock stands high.

	sync2 #(.W(2)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.d({lnk.sck, lnk.sd}),
		.q(sync_q)
	);

	wire sck_s = sync_q[1];
	wire sd_s = sync_q[0];
	wire rise = sck_s & ~sck_p_r;
	wire fall = ~sck_s & sck_p_r;
	wire sd_rise = sd_s & ~sd_p_r;
	// The reset sequence ends when the clock falls after enough pulses.
	wire seq_done = fall & (pulse_r == `RESET_PULSES);

	// Edge history and pulse counting; the counter saturates at its target.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sck_p_r <= 1'b0;
			sd_p_r <= 1'b0;
			pulse_r <= 3'd0;
		end else if (ce) begin
			sck_p_r <= sck_s;
			sd_p_r <= sd_s;
			if (rise || fall)
				pulse_r <= 3'd0;
			else if (sck_s && sd_rise && pulse_r != `RESET_PULSES)
				pulse_r <= pulse_r + 3'd1;
		end
	end

	// ==========================================================================
	// Command engine state.
	dev_state_t st_r; // Engine state.
	logic [2:0] bit_r; // Bit within the incoming byte.
	logic [7:0] rx_r; // Incoming shift register.
	logic [7:0] cmd_r; // Command byte.
	logic [7:0] len_r; // Length byte.
	logic [7:0] didx_r; // Data byte index.
	logic [31:0] word_r; // Last four data bytes.
	logic [7:0] csum_r; // Command checksum.
	logic start_buf_r; // Receiving buffer at command start.
	logic [2:0] obit_r; // Bit within the outgoing byte.
	logic [6:0] oidx_r; // Outgoing byte index.
	logic [7:0] tx_r; // Outgoing shift register.
	logic [7:0] scsum_r; // Solution checksum.
	logic active_r; // Buffer being calculated.
	logic [3:0] mk_cnt_r; // Marker pattern counter.
	logic [3:0] wptr_r; // Next ring slot to write.
	logic [31:0] ring_r [0:11]; // Solution ring.
	logic [31:0] task_mem [0:1][0:19]; // Two job images.

	wire recv_buf = ~active_r;
	wire [7:0] rx_byte = {rx_r[6:0], sd_s};
	wire byte_in = rise & (bit_r == 3'd7);
	wire in_phase = (st_r == S_CMD) | (st_r == S_LEN) | (st_r == S_DATA);
	wire data_byte = byte_in & (st_r == S_DATA);
	wire exec = fall & (st_r == S_EXEC);
	// Codes without a handled bit, the legacy toggle among them, fall through with no effect.
	wire do_force = exec & cmd_r[`CMD_BIT_FORCE];
	wire do_clock = exec & cmd_r[`CMD_BIT_CLOCK];
	wire do_mask = exec & cmd_r[`CMD_BIT_MASK];
	wire clk_ok = (word_r[`CLK_FLAG_HI] == word_r[`CLK_FLAG_LO]) &&
		(word_r[`CLK_CODE_HI] == word_r[`CLK_CODE_LO]);
	wire job_wr = data_byte & cmd_r[`CMD_BIT_TASK] & (didx_r < `JOB_BYTES);
	wire do_switch = task_done | do_force;
	wire [6:0] last_idx = cmd_r[`CMD_BIT_READ] ? `OUT_SCSUM_IDX : `OUT_CSUM_IDX;
	wire out_end = fall & (st_r == S_OUT) & (obit_r == 3'd7) & (oidx_r == last_idx);

	// ==========================================================================
	// Outgoing byte selection for the byte after the current one.
	wire [6:0] nidx = oidx_r + 7'd1;
	wire [6:0] nk = oidx_r - 7'd1;
	wire [3:0] ri = (nk[5:2] > `RING_LAST) ? 4'd0 : nk[5:2];
	wire [31:0] nword = ring_r[ri];
	wire [31:0] nsh = nword >> {~nk[1:0], 3'b000};
	wire sol_byte = (nidx >= `OUT_SOL_FIRST) & (nidx <= `OUT_SOL_LAST);
	wire [7:0] next_byte = (nidx == `OUT_CSUM_IDX) ? csum_r :
		((nidx == `OUT_SCSUM_IDX) ? scsum_r : nsh[7:0]);
	wire [7:0] status_byte = {progress_nib, start_buf_r, start_buf_r, recv_buf, recv_buf};
	wire live_bits = (st_r == S_OUT) & (oidx_r == `OUT_STATUS_IDX) & (obit_r[2:1] == 2'b11);

	// The two status LSBs follow the buffer switch live, as they are sent.
	assign lnk.dev_do = live_bits ? recv_buf : tx_r[7];

	// State transitions; a finished reset sequence restarts from any state.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= S_IDLE;
		end else if (ce) begin
			if (seq_done)
				st_r <= S_CMD;
			else begin
				case (st_r)
				S_CMD: if (byte_in) st_r <= S_LEN;
				S_LEN: if (byte_in) st_r <= S_DATA;
				S_DATA: if (byte_in && didx_r == len_r) st_r <= S_EXEC;
				S_EXEC: if (fall) st_r <= S_OUT;
				S_OUT: if (out_end) st_r <= S_IDLE;
				default: st_r <= st_r;
				endcase
			end
		end
	end

	// Incoming bytes: sampled on rising clock edges, summed into the checksum.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bit_r <= 3'd0;
			rx_r <= 8'h00;
			cmd_r <= 8'h00;
			len_r <= 8'h00;
			didx_r <= 8'h00;
			word_r <= 32'h0;
			csum_r <= 8'h00;
			start_buf_r <= 1'b0;
		end else if (ce) begin
			if (seq_done) begin
				bit_r <= 3'd0;
				csum_r <= 8'h00;
				start_buf_r <= recv_buf;
			end else if (rise && in_phase) begin
				bit_r <= bit_r + 3'd1;
				rx_r <= rx_byte;
				if (byte_in) begin
					csum_r <= csum_r + rx_byte;
					if (st_r == S_CMD)
						cmd_r <= rx_byte;
					if (st_r == S_LEN) begin
						len_r <= rx_byte;
						didx_r <= 8'h00;
					end
					if (st_r == S_DATA) begin
						didx_r <= didx_r + 8'd1;
						word_r <= {word_r[23:0], rx_byte};
					end
				end
			end
		end
	end

	// Outgoing bytes: driven from the falling edge after the last data bit.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			obit_r <= 3'd0;
			oidx_r <= 7'd0;
			tx_r <= 8'h00;
			scsum_r <= 8'h00;
			lnk.dev_oe <= 1'b0;
		end else if (ce) begin
			if (seq_done || out_end) begin
				lnk.dev_oe <= 1'b0;
			end else if (exec) begin
				obit_r <= 3'd0;
				oidx_r <= `OUT_STATUS_IDX;
				tx_r <= status_byte;
				scsum_r <= 8'h00;
				lnk.dev_oe <= 1'b1;
			end else if (fall && st_r == S_OUT) begin
				obit_r <= obit_r + 3'd1;
				if (obit_r == 3'd7) begin
					oidx_r <= nidx;
					tx_r <= next_byte;
					if (sol_byte)
						scsum_r <= scsum_r + nsh[7:0];
				end else
					tx_r <= {tx_r[6:0], 1'b0};
			end
		end
	end

	// ==========================================================================
	// Task buffers: job bytes land in the receiving buffer, MSB-first per dword.
	// Memory has no reset; a job must be loaded before its buffer is used.
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			if (job_wr)
				task_mem[recv_buf][didx_r[6:2]][{~didx_r[1:0], 3'b000} +: 8] <= rx_byte;
			else if (do_mask)
				task_mem[recv_buf][`JOB_MASK_WORD] <= word_r;
			job_rd_data <= task_mem[active_r][job_rd_idx];
		end
	end

	// Search mask of the active job, decoded for the core.
	wire [31:0] act_mask = task_mem[active_r][`JOB_MASK_WORD];

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fix_bits_mask <= 32'h0;
			fix_value <= 16'h0;
		end else if (ce) begin
			fix_bits_mask <= ~(32'hffffffff << act_mask[`MASK_COUNT]);
			fix_value <= act_mask[15:0] ^ `MASK_XOR;
		end
	end

	// Buffer switching and the clock generator word.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			active_r <= 1'b0;
			clk_ctrl <= 32'h0;
			clk_load <= 1'b0;
		end else if (ce) begin
			if (do_switch)
				active_r <= ~active_r;
			clk_load <= do_clock & clk_ok;
			if (do_clock && clk_ok)
				clk_ctrl <= word_r;
		end
	end

	assign active_buf = active_r;

	// ==========================================================================
	// Solution ring. A marker on the same cycle as a solution wins; the solution is lost.
	wire ring_we = do_switch | sol_valid;
	wire [31:0] ring_wd = do_switch ? {mk_cnt_r, `MARK_BODY} : (sol_value ^ `SOL_XOR);

	// Write pointer runs from slot 11 down to slot 0 and wraps.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wptr_r <= `RING_LAST;
			mk_cnt_r <= 4'd0;
		end else if (ce) begin
			if (ring_we)
				wptr_r <= (wptr_r == 4'd0) ? `RING_LAST : wptr_r - 4'd1;
			if (do_switch)
				mk_cnt_r <= mk_cnt_r + 4'd1;
		end
	end

	// One storage word per ring slot.
	for (genvar i = 0; i < 12; i++) begin : g_ring
		always_ff @(posedge sys_clk) begin
			if (!rst_n)
				ring_r[i] <= 32'h0;
			else if (ce && ring_we && wptr_r == 4'(i))
				ring_r[i] <= ring_wd;
		end
	end

endmodule

// File: rtl/hash_host.sv
// Controller end of the serial control link, with a Wishbone register port.
module hash_host
	import hash_link_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	hash_link_if.host lnk
);
`include "hash_link_consts.svh"

	// ==========================================================================
	// Register state and buffers.
	host_state_t hst_r; // Sequencer state.
	logic [7:0] code_r; // Command code to send.
	logic [7:0] len_r; // Length byte to send.
	logic [7:0] txbuf [0:79]; // Outgoing data bytes.
	logic [7:0] rxbuf [0:50]; // Returned bytes: status, checksum, solutions.
	logic [7:0] div_r; // Half-period divider.
	logic [3:0] step_r; // Reset sequence step.
	logic [7:0] tbi_r; // Outgoing byte index.
	logic [2:0] tbit_r; // Outgoing bit index.
	logic [5:0] rbi_r; // Returned byte index.
	logic [2:0] rbit_r; // Returned bit index.
	logic [7:0] rsr_r; // Returned shift register.
	logic sd_s; // Synchronised line.

	sync2 #(.W(1)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(lnk.sd),
		.q(sd_s)
	);

	// ==========================================================================
	// Wishbone decode; every access is acknowledged one cycle after the strobe.
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire busy = (hst_r != H_IDLE);
	wire sel_ctrl = (wb_adr_i == `HREG_CTRL);
	wire sel_rx = (wb_adr_i[9:8] == 2'b01) & (wb_adr_i[7:2] <= 6'd50);
	// The data window runs past 0x2ff, so only bit 9 marks it and bits 8:2 give the byte.
	wire sel_tx = wb_adr_i[9] & (wb_adr_i[8:2] <= 7'd79);
	wire wr_ctrl = req & wb_we_i & sel_ctrl & ~busy;
	wire go = wr_ctrl & wb_sel_i[2] & wb_dat_i[`HCTRL_GO];
	wire [31:0] rd_data = sel_ctrl ? {busy, 15'h0, len_r, code_r} :
		(sel_rx ? {24'h0, rxbuf[wb_adr_i[7:2]]} : 32'h0);

	// Register writes; control is locked while a command runs.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			code_r <= 8'h00;
			len_r <= 8'h00;
		end else if (ce) begin
			wb_ack_o <= req;
			wb_dat_o <= rd_data;
			if (wr_ctrl && wb_sel_i[0])
				code_r <= wb_dat_i[7:0];
			if (wr_ctrl && wb_sel_i[1])
				len_r <= wb_dat_i[15:8];
		end
	end

	// Data bytes to send; no reset since software fills them before use.
	always_ff @(posedge sys_clk) begin
		if (ce && req && wb_we_i && sel_tx && wb_sel_i[0])
			txbuf[wb_adr_i[8:2]] <= wb_dat_i[7:0];
	end

	// ==========================================================================
	// Serial engine: one tick per half period of the serial clock.
	wire tick = (div_r == 8'(`SCK_HALF_CYC - 1));
	wire [7:0] tsel = (tbit_r == 3'd7) ? tbi_r + 8'd1 : tbi_r;
	wire [7:0] dsel = (tsel < 8'd2 || tsel > 8'd81) ? 8'd0 : tsel - 8'd2;
	wire [7:0] tbyte = (tsel == 8'd0) ? code_r : ((tsel == 8'd1) ? len_r : txbuf[dsel[6:0]]);
	wire [2:0] bpos = ~(tbit_r + 3'd1);
	wire [7:0] tx_last = len_r + 8'd2;
	wire [5:0] rx_last = code_r[`CMD_BIT_READ] ? 6'd50 : 6'd1;
	wire [7:0] rx_byte = {rsr_r[6:0], sd_s};

	// Returned bytes are stored as they complete.
	always_ff @(posedge sys_clk) begin
		if (ce && tick && hst_r == H_RX && !lnk.sck && rbit_r == 3'd7)
			rxbuf[rbi_r] <= rx_byte;
	end

	// Sequencer: reset pulses, command bytes out, answer bytes in.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			hst_r <= H_IDLE;
			div_r <= 8'd0;
			step_r <= 4'd0;
			tbi_r <= 8'd0;
			tbit_r <= 3'd0;
			rbi_r <= 6'd0;
			rbit_r <= 3'd0;
			rsr_r <= 8'h00;
			lnk.sck <= 1'b0;
			lnk.host_do <= 1'b0;
			lnk.host_oe <= 1'b0;
		end else if (ce) begin
			div_r <= (tick || !busy) ? 8'd0 : div_r + 8'd1;
			case (hst_r)
			H_IDLE: if (go) begin
				hst_r <= H_RST;
				step_r <= 4'd0;
				lnk.host_do <= 1'b0;
				lnk.host_oe <= 1'b1;
			end
			// Clock high, four data pulses, then clock low with the first bit.
			H_RST: if (tick) begin
				step_r <= step_r + 4'd1;
				if (step_r == 4'd0)
					lnk.sck <= 1'b1;
				else if (step_r < 4'd9)
					lnk.host_do <= ~lnk.host_do;
				else begin
					lnk.sck <= 1'b0;
					lnk.host_do <= code_r[7];
					tbi_r <= 8'd0;
					tbit_r <= 3'd0;
					hst_r <= H_TX;
				end
			end
			// The device samples on rising edges; data changes with the fall.
			H_TX: if (tick) begin
				lnk.sck <= ~lnk.sck;
				if (lnk.sck) begin
					tbit_r <= tbit_r + 3'd1;
					if (tbit_r == 3'd7)
						tbi_r <= tsel;
					if (tbit_r == 3'd7 && tbi_r == tx_last) begin
						lnk.host_oe <= 1'b0;
						rbi_r <= 6'd0;
						rbit_r <= 3'd0;
						hst_r <= H_RX;
					end else
						lnk.host_do <= tbyte[bpos];
				end
			end
			// Answer bits are taken at the rising edge this end makes.
			H_RX: if (tick) begin
				lnk.sck <= ~lnk.sck;
				if (!lnk.sck) begin
					rsr_r <= rx_byte;
					rbit_r <= rbit_r + 3'd1;
					if (rbit_r == 3'd7) begin
						rbi_r <= rbi_r + 6'd1;
						if (rbi_r == rx_last)
							hst_r <= H_END;
					end
				end
			end
			// A last falling edge lets the device release the line.
			H_END: if (tick) begin
				lnk.sck <= 1'b0;
				hst_r <= H_IDLE;
			end
			default: hst_r <= H_IDLE;
			endcase
		end
	end

endmodule

// File: tb/link_properties.sv
// Concurrent checks on the wire between the controller end and the device end.
module link_properties (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic host_do,
	input wire logic host_oe,
	input wire logic dev_do,
	input wire logic dev_oe,
	input wire logic sd
);
	timeunit 1ns;
	timeprecision 1ns;

	// ====================
	// All checks sample on the system clock and rest while reset is held.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// Two drivers on the shared line would fight, so the ends take turns.
	chk_one_driver: assert property (!(dev_oe && host_oe))
		else $error("Both ends drive the data line.");
	chk_sck_half_period: assert property ($changed(sck) |=> $stable(sck) [*7])
		else $error("Serial clock half period too short.");
	// The device samples a few cycles after the rise, so data must hold.
	chk_host_hold: assert property ($rose(sck) && host_oe |-> $stable(host_do) ##1 $stable(host_do) [*6])
		else $error("Controller data moved near a rising edge.");
	chk_dev_on_low: assert property (dev_oe && $changed(dev_do) |-> !sck)
		else $error("Device data moved while the clock was high.");
	chk_dev_bit_time: assert property (dev_oe && $changed(dev_do) |=> $stable(dev_do) [*8])
		else $error("Device bit shorter than half a period.");
	chk_turn_around: assert property ($rose(dev_oe) |-> !host_oe && !sck)
		else $error("Device took the line too early.");
	chk_dev_release: assert property ($fell(dev_oe) |-> !sck)
		else $error("Device released the line with the clock high.");
	chk_frame_start: assert property ($rose(host_oe) |-> !sck && !host_do && !dev_oe)
		else $error("Frame did not start from a low line.");
	chk_idle_pull_up: assert property (!dev_oe && !host_oe |-> sd)
		else $error("Released line is not high.");
	// The controller lets go of the line with the fall after its last bit.
	chk_host_release: assert property ($fell(host_oe) |-> $fell(sck))
		else $error("Controller released the line away from a falling edge.");
endmodule

// File: tb/test_hash_chip_command_set.sv
// Self-checking bench for both ends of the hashing chip serial link.
module test_hash_chip_command_set;
	timeunit 1ns;
	timeprecision 1ns;

	// ====================
	// Bench signals; the link is reached only through the controller.
	logic sys_clk, rst_n, ce, wb_cyc, wb_stb, wb_we, wb_ack, task_done, sol_valid, active_buf, clk_load, act;
	logic [9:0] wb_adr;
	logic [3:0] wb_sel, progress_nib;
	logic [31:0] wb_wdat, wb_rdat, sol_value, job_rd_data, clk_ctrl, fix_bits_mask, q, v, mword;
	logic [15:0] fix_value;
	logic [4:0] job_rd_idx;
	logic [7:0] tx[80], job[80];
	// Model of the solution ring, as read, with a mask of known bits.
	logic [31:0] ring[12], ring_m[12];
	logic [31:0] words[3] = '{32'h038bf7c0, 32'h038bf780, 32'h038be7c0};
	int errors, checked, wp, loads;
	typedef struct packed {logic [31:0] e; logic [31:0] m;} note_t;
	note_t notes[$], nt;

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	hash_link_if hash_link_if_i();
	hash_host hash_host_i(.sys_clk, .rst_n, .ce, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.lnk(hash_link_if_i.host));
	hash_dev hash_dev_i(.sys_clk, .rst_n, .ce, .lnk(hash_link_if_i.device), .task_done, .sol_valid, .sol_value,
		.progress_nib, .job_rd_idx, .job_rd_data, .active_buf, .clk_ctrl, .clk_load, .fix_bits_mask, .fix_value);
	link_properties link_properties_i(.sys_clk, .rst_n, .sck(hash_link_if_i.sck), .host_do(hash_link_if_i.host_do),
		.host_oe(hash_link_if_i.host_oe), .dev_do(hash_link_if_i.dev_do), .dev_oe(hash_link_if_i.dev_oe),
		.sd(hash_link_if_i.sd));

	task automatic conclude();
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask

	// ====================
	// Read monitor: each read answer is matched against the oldest note.
	always @(posedge sys_clk) begin
		if (wb_ack === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0 && notes.size() > 0) begin
			nt = notes.pop_front();
			// A zero mask marks a poll whose value is not judged.
			if (nt.m != 0)
				cmp("wb_dat_o", nt.e & nt.m, wb_rdat & nt.m);
		end
	end

	// Counts load strobes so refused clock words can be seen.
	always @(posedge sys_clk) begin
		if (clk_load === 1'b1)
			loads++;
	end

	// One classic cycle; the request holds until ack is sampled high.
	task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge sys_clk);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, we, a, d, s};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			conclude();
		end
		q = wb_rdat;
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
	endtask

	task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{e, m});
		wb(1'b0, a, 32'h0, 4'hf);
	endtask

	// Sends one command, waits for the link, then judges status and checksum.
	task automatic cmd(input logic [7:0] code, input logic [7:0] len, input logic rs, input logic re);
		logic [7:0] cs;
		int n;
		cs = code + len;
		for (int i = 0; i <= len; i++) begin
			cs += tx[i];
			wb(1'b1, 10'h200 + 10'(4 * i), {24'h0, tx[i]}, 4'h1);
		end
		wb(1'b1, 10'h000, {15'h0, 1'b1, len, code}, 4'h7);
		n = 0;
		do begin
			rd(10'h000, 32'h0, 32'h0);
			n++;
		end while (q[31] !== 1'b0 && n < 20000);
		if (n >= 20000) begin
			errors++;
			conclude();
		end
		rd(10'h100, {24'h0, progress_nib, rs, rs, re, re}, 32'hff);
		rd(10'h104, {24'h0, cs}, 32'hff);
	endtask

	// Ring entries go from slot 11 downward and wrap back to 11.
	task automatic put(input logic [31:0] e, input logic [31:0] m);
		ring[wp] = e;
		ring_m[wp] = m;
		wp = (wp == 0) ? 11 : wp - 1;
	endtask

	// A switch flips the buffers and leaves a marker whose top nibble is not judged.
	task automatic swap();
		act = ~act;
		put(32'h0ffffffc, 32'h0fffffff);
	endtask

	task automatic pulse_done();
		@(posedge sys_clk);
		task_done <= 1'b1;
		@(posedge sys_clk);
		task_done <= 1'b0;
		swap();
	endtask

	task automatic read_sols();
		logic [31:0] r, m;
		logic [7:0] s;
		logic full;
		tx[0] = 8'h00;
		cmd(8'h04, 8'h00, ~act, ~act);
		s = 8'h00;
		full = 1'b1;
		for (int k = 0; k < 48; k++) begin
			r = ring[k / 4] >> (8 * (3 - k % 4));
			m = ring_m[k / 4] >> (8 * (3 - k % 4));
			s += r[7:0];
			full &= (m[7:0] == 8'hff);
			rd(10'h108 + 10'(4 * k), {24'h0, r[7:0]}, {24'h0, m[7:0]});
		end
		// The sum is judged only when no marker nibble is unknown.
		rd(10'h1c8, {24'h0, s}, {24'h0, {8{full}}});
	endtask

	// ====================
	// Main sequence.
	initial begin
		{rst_n, wb_cyc, wb_stb, wb_we, task_done, sol_valid, wb_adr, wb_sel, wb_wdat, sol_value, job_rd_idx} = '0;
		ce = 1'b1;
		{errors, checked, loads} = '0;
		wp = 11;
		act = 1'b0;
		foreach (ring_m[i]) ring_m[i] = 32'h0;
		void'($urandom(32'hfb26f5d8));
		progress_nib = 4'($urandom());
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		// An unmapped place reads as zero.
		rd(10'h3f0, 32'h0, 32'hffffffff);
		// Only the first clock word has matching copies.
		for (int i = 0; i < 3; i++) begin
			{tx[0], tx[1], tx[2], tx[3]} = words[i];
			cmd(8'h08, 8'h03, 1'b1, 1'b1);
			@(negedge sys_clk);
			cmp("clk_ctrl", words[0], clk_ctrl);
		end
		cmp("clk_load", 32'h1, 32'(loads));
		tx[0] = 8'($urandom());
		cmd(8'h10, 8'h00, 1'b1, 1'b1);
		@(negedge sys_clk);
		cmp("clk_ctrl", words[0], clk_ctrl);
		cmp("active_buf", 32'(act), 32'(active_buf));
		// Full job, then a short one over its first dword, then the mask.
		// State, midstate and message bytes go out encoded; the mask dword does not.
		for (int i = 0; i < 80; i++) tx[i] = 8'($urandom()) ^ ((i < 76) ? 8'haa : 8'h00);
		job = tx;
		cmd(8'h01, 8'h4f, 1'b1, 1'b1);
		for (int i = 0; i < 4; i++) begin
			tx[i] = 8'($urandom());
			job[i] = tx[i];
		end
		cmd(8'h01, 8'h03, 1'b1, 1'b1);
		mword = {16'h0007, 16'($urandom())};
		{tx[0], tx[1], tx[2], tx[3]} = mword;
		{job[76], job[77], job[78], job[79]} = mword;
		cmd(8'h20, 8'h03, 1'b1, 1'b1);
		tx[0] = 8'h00;
		cmd(8'h02, 8'h00, 1'b1, 1'b0);
		swap();
		@(negedge sys_clk);
		cmp("active_buf", 32'h1, 32'(active_buf));
		cmp("fix_bits_mask", 32'h7f, fix_bits_mask);
		cmp("fix_value", 32'(mword[15:0] ^ 16'haaaa), 32'(fix_value));
		for (int i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			job_rd_idx <= 5'(i);
			@(posedge sys_clk);
			@(negedge sys_clk);
			cmp("job_rd_data", {job[4 * i], job[4 * i + 1], job[4 * i + 2], job[4 * i + 3]}, job_rd_data);
		end
		pulse_done();
		@(negedge sys_clk);
		cmp("active_buf", 32'(act), 32'(active_buf));
		// A low clock enable freezes the device, so a completion pulse is lost.
		@(posedge sys_clk);
		{ce, task_done} <= 2'b01;
		repeat (2) @(posedge sys_clk);
		{ce, task_done} <= 2'b10;
		@(negedge sys_clk);
		cmp("active_buf", 32'(act), 32'(active_buf));
		// Twelve solutions overwrite every slot, the two markers included.
		for (int i = 0; i < 12; i++) begin
			@(posedge sys_clk);
			v = $urandom();
			sol_value <= v;
			sol_valid <= 1'b1;
			@(posedge sys_clk);
			sol_valid <= 1'b0;
			put(v ^ 32'h0aaaaaaa, 32'hffffffff);
		end
		read_sols();
		pulse_done();
		read_sols();
		conclude();
	end
endmodule
